// File: design/bgl_consts.svh
`ifndef BGL_CONSTS_SVH
`define BGL_CONSTS_SVH

// Sizes
`define BGL_NUM_OUT 10
`define BGL_NUM_IN 8
`define BGL_NUM_RAIL 10
`define BGL_NUM_TYPE 20
`define BGL_TERM_OUTS 8
`define BGL_PSEL_NUM 3

// Byte address map: bits [9:8] select the bank
`define BGL_BANK_OUT 2'h0
`define BGL_BANK_GLB 2'h1
`define BGL_OUT_STRIDE 10'h010
`define BGL_SUB_CFG 2'h0
`define BGL_SUB_TERM0 2'h1
`define BGL_SUB_TERM1 2'h2
`define BGL_SUB_DELAY 2'h3
`define BGL_GLB_IN_CFG 3'h0
`define BGL_GLB_FUNC 3'h1
`define BGL_GLB_MARGIN 3'h2
`define BGL_GLB_LATCH_CLR 3'h3
`define BGL_GLB_IRQ_STAT 3'h4
`define BGL_GLB_IRQ_CLR 3'h5
`define BGL_GLB_IRQ_EN 3'h6
`define BGL_GLB_STATE 3'h7

// Output config fields
`define BGL_CFG_HOST 0
`define BGL_CFG_LEVEL 1
`define BGL_CFG_DLY_ASSERT 2
`define BGL_CFG_DLY_DEASSERT 3
`define BGL_CFG_IGNORE 4
`define BGL_CFG_SM 5
`define BGL_CFG_OE 6

// Term fields
`define BGL_TERM_OUT_LSB 0
`define BGL_TERM_IN_LSB 8
`define BGL_TERM_RAIL_LSB 16
`define BGL_TERM_TYPE_LSB 26

// Special input function fields, 4 bits each: valid at bit 3, pin in [2:0]
`define BGL_FUNC_FAULT_LSB 0
`define BGL_FUNC_CLEAR_LSB 4
`define BGL_FUNC_MEN_LSB 8
`define BGL_FUNC_MDIR_LSB 12

// Interrupt bits
`define BGL_IRQ_FAULT 0
`define BGL_IRQ_LATCH 1
`define BGL_IRQ_CHANGE 2

// Reset values
`define BGL_RST_WORD 32'h0000_0000
`define BGL_RST_IN_CFG 32'h0000_00FF

// Timing: delay field counts ticks of 1 us
`define BGL_CLK_NS 10
`define BGL_TICK_NS 1000
`define BGL_TICK_CYC (`BGL_TICK_NS / `BGL_CLK_NS)

`endif

// File: design/bgl_pkg.sv
package bgl_pkg;
  typedef logic [31:0] bgl_word_t;
  typedef enum logic [0:0] {
    BGL_IDLE = 1'b0,
    BGL_BUSY = 1'b1
  } bgl_phase_e;
endpackage

// File: design/bgl_top.sv
// What this block does
// - Each output is the OR of at most two AND product terms.
// - Term inputs: first eight outputs, general inputs and rail-status flags.
// - Each term picks one rail-status type and any subset of rails of it.
// - Latching status types hold once set until host command or clear pin.
// - Delay applies on assertion, deassertion, both edges or neither.
// - Normal delay: a result reverting before the delay leaves the pin unchanged.
// - Ignore mode: even brief changes pass after the delay; inputs ignored meanwhile.
// - Ignore mode: every produced output pulse lasts at least the delay.
// - State-machine mode: term 0 while result true, term 1 while false.
// - Host may drive an output level directly instead of the logic.
// - Each special input function maps to at most one input pin.
// - Deassertion of the fault-enable input is treated as a fault.
// - The latch-clear input, when asserted, clears the latched rail flags.
// - Margin-enable input puts every margin-enabled rail into a margined state.
// - Margin direction input: asserted is margin low, deasserted margin high.
// - Every general input has its own polarity, active low or high.
// - First three defined inputs also drive the pin-selected rail state bits.
`timescale 1ns/1ps
`include "bgl_consts.svh"
`default_nettype none

module bgl_top import bgl_pkg::*; (
  input wire logic MCLK,
  input wire logic RST_B,
  input wire logic CE,
  input wire logic [`BGL_NUM_IN-1:0] GEN_IN_PIN,
  input wire logic [`BGL_NUM_TYPE*`BGL_NUM_RAIL-1:0] RAIL_STATUS,
  input wire logic [9:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  output logic [`BGL_NUM_OUT-1:0] GEN_OUT,
  output logic [`BGL_NUM_OUT-1:0] GEN_OUT_OE,
  output logic [`BGL_NUM_RAIL-1:0] MARGIN_EN,
  output logic MARGIN_LOW,
  output logic IN_FAULT,
  output logic [`BGL_PSEL_NUM-1:0] PIN_SEL,
  output logic IRQ
);

  localparam int NO = `BGL_NUM_OUT;
  localparam int NI = `BGL_NUM_IN;
  localparam int NR = `BGL_NUM_RAIL;
  localparam int NT = `BGL_NUM_TYPE;
  localparam int TICK_CYC = `BGL_TICK_CYC;

  function automatic logic [31:0] fn_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // One field names one pin, so a function can never sit on two pins
  function automatic logic fn_pin(input logic [3:0] f, input logic [NI-1:0] act);
    return f[3] & act[f[2:0]];
  endfunction

  function automatic logic [NR-1:0] fn_rail(input logic [5:0] ty, input logic [NT*NR-1:0] raw,
                                            input logic [NT*NR-1:0] lat);
    logic [NR-1:0] r;
    r = '0;
    if (ty[4:0] < 5'(NT)) begin
      r = ty[5] ? lat[int'(ty[4:0])*NR +: NR] : raw[int'(ty[4:0])*NR +: NR];
    end
    return r;
  endfunction

  // Empty term reads false, so an unused term does not force the OR high
  function automatic logic fn_term(input logic [31:0] t, input logic [NO-1:0] outs, input logic [NI-1:0] ins,
                                   input logic [NR-1:0] rail);
    logic [7:0] mo;
    logic [NI-1:0] mi;
    logic [NR-1:0] mr;
    mo = t[`BGL_TERM_OUT_LSB +: 8];
    mi = t[`BGL_TERM_IN_LSB +: NI];
    mr = t[`BGL_TERM_RAIL_LSB +: NR];
    return ((mo != '0) || (mi != '0) || (mr != '0)) && ((outs[7:0] & mo) == mo) &&
           ((ins & mi) == mi) && ((rail & mr) == mr);
  endfunction

  function automatic logic fn_edge_dly(input logic [31:0] c, input logic v);
    return v ? c[`BGL_CFG_DLY_ASSERT] : c[`BGL_CFG_DLY_DEASSERT];
  endfunction

  bgl_word_t cfg [NO];
  bgl_word_t term0 [NO];
  bgl_word_t term1 [NO];
  bgl_word_t dly [NO];
  bgl_word_t in_cfg;
  bgl_word_t func;
  bgl_word_t margin_mask;
  bgl_word_t irq_en;
  logic [2:0] irq_stat;
  logic ack;
  logic req;
  logic wr_go;
  logic [3:0] idx;
  logic out_bank;
  logic glb_bank;
  logic [31:0] rd_word;
  logic latch_clr_cmd;
  logic [2:0] irq_clr;
  logic [NI-1:0] in_s1;
  logic [NI-1:0] in_s2;
  logic [NI-1:0] in_act;
  logic [NT*NR-1:0] lat;
  logic lat_clear;
  logic [NO-1:0] res;
  logic [NO-1:0] res_q;
  bgl_phase_e phase [NO];
  logic [NO-1:0] tgt;
  logic [16:0] cnt [NO];
  logic [6:0] pre_cnt;
  logic tick;
  logic [`BGL_PSEL_NUM-1:0] next_pin_sel;
  logic [NO-1:0] out_prev;

  // Bus slave: one wait cycle, read data is captured during it
  assign req = AVS_READ | AVS_WRITE;
  assign AVS_WAITREQUEST = req & ~(ack & CE);
  assign wr_go = AVS_WRITE & ack & CE;
  assign idx = AVS_ADDRESS[7:4];
  assign out_bank = (AVS_ADDRESS[9:8] == `BGL_BANK_OUT) && (idx < 4'(NO));
  assign glb_bank = (AVS_ADDRESS[9:8] == `BGL_BANK_GLB) && (AVS_ADDRESS[7:5] == 3'h0);

  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      ack <= 1'b0;
    end else if (CE) begin
      ack <= req & ~ack;
    end
  end

  always_comb begin
    rd_word = '0;
    if (out_bank) begin
      case (AVS_ADDRESS[3:2])
        `BGL_SUB_CFG: rd_word = cfg[idx];
        `BGL_SUB_TERM0: rd_word = term0[idx];
        `BGL_SUB_TERM1: rd_word = term1[idx];
        `BGL_SUB_DELAY: rd_word = dly[idx];
        default: rd_word = '0;
      endcase
    end else if (glb_bank) begin
      case (AVS_ADDRESS[4:2])
        `BGL_GLB_IN_CFG: rd_word = in_cfg;
        `BGL_GLB_FUNC: rd_word = func;
        `BGL_GLB_MARGIN: rd_word = margin_mask;
        `BGL_GLB_IRQ_STAT: rd_word = {29'h0, irq_stat};
        `BGL_GLB_IRQ_EN: rd_word = irq_en;
        `BGL_GLB_STATE: rd_word = {8'h00, in_act, 1'b0, PIN_SEL, IN_FAULT, MARGIN_LOW, GEN_OUT};
        default: rd_word = '0;
      endcase
    end
  end

  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      AVS_READDATA <= '0;
    end else if (CE && AVS_READ && !ack) begin
      AVS_READDATA <= rd_word;
    end
  end

  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      for (int o = 0; o < NO; o++) begin
        cfg[o] <= `BGL_RST_WORD;
        term0[o] <= `BGL_RST_WORD;
        term1[o] <= `BGL_RST_WORD;
        dly[o] <= `BGL_RST_WORD;
      end
      in_cfg <= `BGL_RST_IN_CFG;
      func <= `BGL_RST_WORD;
      margin_mask <= `BGL_RST_WORD;
      irq_en <= `BGL_RST_WORD;
    end else if (wr_go && out_bank) begin
      case (AVS_ADDRESS[3:2])
        `BGL_SUB_CFG: cfg[idx] <= fn_merge(cfg[idx], AVS_WRITEDATA, AVS_BYTEENABLE);
        `BGL_SUB_TERM0: term0[idx] <= fn_merge(term0[idx], AVS_WRITEDATA, AVS_BYTEENABLE);
        `BGL_SUB_TERM1: term1[idx] <= fn_merge(term1[idx], AVS_WRITEDATA, AVS_BYTEENABLE);
        default: dly[idx] <= fn_merge(dly[idx], AVS_WRITEDATA, AVS_BYTEENABLE);
      endcase
    end else if (wr_go && glb_bank) begin
      case (AVS_ADDRESS[4:2])
        `BGL_GLB_IN_CFG: in_cfg <= fn_merge(in_cfg, AVS_WRITEDATA, AVS_BYTEENABLE);
        `BGL_GLB_FUNC: func <= fn_merge(func, AVS_WRITEDATA, AVS_BYTEENABLE);
        `BGL_GLB_MARGIN: margin_mask <= fn_merge(margin_mask, AVS_WRITEDATA, AVS_BYTEENABLE);
        `BGL_GLB_IRQ_EN: irq_en <= fn_merge(irq_en, AVS_WRITEDATA, AVS_BYTEENABLE);
        default: ;
      endcase
    end
  end

  assign latch_clr_cmd = wr_go && glb_bank && (AVS_ADDRESS[4:2] == `BGL_GLB_LATCH_CLR);
  assign irq_clr = (wr_go && glb_bank && (AVS_ADDRESS[4:2] == `BGL_GLB_IRQ_CLR) && AVS_BYTEENABLE[0]) ?
                   AVS_WRITEDATA[2:0] : 3'h0;

  // Input pins are asynchronous
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      in_s1 <= '0;
      in_s2 <= '0;
    end else if (CE) begin
      in_s1 <= GEN_IN_PIN;
      in_s2 <= in_s1;
    end
  end

  assign in_act = ~(in_s2 ^ in_cfg[NI-1:0]);

  // Latched rail flags; a new flag in the clearing cycle survives
  assign lat_clear = latch_clr_cmd | fn_pin(func[`BGL_FUNC_CLEAR_LSB +: 4], in_act);

  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      lat <= '0;
    end else if (CE) begin
      lat <= (lat_clear ? '0 : lat) | RAIL_STATUS;
    end
  end

  // Boolean result per output
  always_comb begin
    logic t0;
    logic t1;
    t0 = 1'b0;
    t1 = 1'b0;
    res = '0;
    for (int o = 0; o < NO; o++) begin
      t0 = fn_term(term0[o], GEN_OUT, in_act,
                   fn_rail(term0[o][`BGL_TERM_TYPE_LSB +: 6], RAIL_STATUS, lat));
      t1 = fn_term(term1[o], GEN_OUT, in_act,
                   fn_rail(term1[o][`BGL_TERM_TYPE_LSB +: 6], RAIL_STATUS, lat));
      if (cfg[o][`BGL_CFG_HOST]) begin
        res[o] = cfg[o][`BGL_CFG_LEVEL];
      end else if (cfg[o][`BGL_CFG_SM]) begin
        res[o] = res_q[o] ? t0 : t1;
      end else begin
        res[o] = t0 | t1;
      end
    end
  end

  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      res_q <= '0;
    end else if (CE) begin
      res_q <= res;
    end
  end

  // Shared 1 us tick; strict compare keeps delays from running one tick short
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      pre_cnt <= '0;
    end else if (CE) begin
      pre_cnt <= (pre_cnt == 7'(TICK_CYC - 1)) ? 7'h00 : pre_cnt + 7'h01;
    end
  end

  assign tick = (pre_cnt == 7'(TICK_CYC - 1));

  // Delay engine
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      GEN_OUT <= '0;
      tgt <= '0;
      for (int o = 0; o < NO; o++) begin
        phase[o] <= BGL_IDLE;
        cnt[o] <= '0;
      end
    end else if (CE) begin
      for (int o = 0; o < NO; o++) begin
        if (cfg[o][`BGL_CFG_HOST]) begin
          GEN_OUT[o] <= res[o];
          phase[o] <= BGL_IDLE;
          cnt[o] <= '0;
        end else if (cfg[o][`BGL_CFG_IGNORE]) begin
          case (phase[o])
            BGL_IDLE: begin
              if (res[o] != GEN_OUT[o]) begin
                tgt[o] <= res[o];
                cnt[o] <= '0;
                if (fn_edge_dly(cfg[o], res[o])) begin
                  phase[o] <= BGL_BUSY;
                end else begin
                  GEN_OUT[o] <= res[o];
                  // Undelayed return edge would allow a short pulse, so hold
                  phase[o] <= fn_edge_dly(cfg[o], ~res[o]) ? BGL_IDLE : BGL_BUSY;
                end
              end
            end
            BGL_BUSY: begin
              if (cnt[o] > {1'b0, dly[o][15:0]}) begin
                if (GEN_OUT[o] != tgt[o]) begin
                  GEN_OUT[o] <= tgt[o];
                  cnt[o] <= '0;
                  phase[o] <= fn_edge_dly(cfg[o], ~tgt[o]) ? BGL_IDLE : BGL_BUSY;
                end else begin
                  phase[o] <= BGL_IDLE;
                end
              end else if (tick) begin
                cnt[o] <= cnt[o] + 17'h0_0001;
              end
            end
            default: phase[o] <= BGL_IDLE;
          endcase
        end else begin
          phase[o] <= BGL_IDLE;
          if (res[o] == GEN_OUT[o]) begin
            cnt[o] <= '0;
          end else if (!fn_edge_dly(cfg[o], res[o])) begin
            GEN_OUT[o] <= res[o];
          end else if (res[o] != res_q[o]) begin
            cnt[o] <= '0;
          end else if (cnt[o] > {1'b0, dly[o][15:0]}) begin
            GEN_OUT[o] <= res[o];
            cnt[o] <= '0;
          end else if (tick) begin
            cnt[o] <= cnt[o] + 17'h0_0001;
          end
        end
      end
    end
  end

  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      GEN_OUT_OE <= '0;
    end else if (CE) begin
      for (int o = 0; o < NO; o++) begin
        GEN_OUT_OE[o] <= cfg[o][`BGL_CFG_OE];
      end
    end
  end

  // Special input functions
  always_comb begin
    int k;
    k = 0;
    next_pin_sel = '0;
    for (int i = 0; i < NI; i++) begin
      if (in_cfg[8 + i] && k < `BGL_PSEL_NUM) begin
        next_pin_sel[k] = in_act[i];
        k = k + 1;
      end
    end
  end

  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      MARGIN_EN <= '0;
      MARGIN_LOW <= 1'b0;
      IN_FAULT <= 1'b0;
      PIN_SEL <= '0;
    end else if (CE) begin
      MARGIN_EN <= fn_pin(func[`BGL_FUNC_MEN_LSB +: 4], in_act) ? margin_mask[NR-1:0] : '0;
      MARGIN_LOW <= fn_pin(func[`BGL_FUNC_MEN_LSB +: 4], in_act) &
                    fn_pin(func[`BGL_FUNC_MDIR_LSB +: 4], in_act);
      IN_FAULT <= func[`BGL_FUNC_FAULT_LSB + 3] & ~fn_pin(func[`BGL_FUNC_FAULT_LSB +: 4], in_act);
      PIN_SEL <= next_pin_sel;
    end
  end

  // Sticky events; set beats a clear in the same cycle
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      irq_stat <= '0;
      out_prev <= '0;
      IRQ <= 1'b0;
    end else if (CE) begin
      out_prev <= GEN_OUT;
      irq_stat[`BGL_IRQ_FAULT] <= (irq_stat[`BGL_IRQ_FAULT] & ~irq_clr[`BGL_IRQ_FAULT]) | IN_FAULT;
      irq_stat[`BGL_IRQ_LATCH] <= (irq_stat[`BGL_IRQ_LATCH] & ~irq_clr[`BGL_IRQ_LATCH]) |
                                  (|(RAIL_STATUS & ~lat));
      irq_stat[`BGL_IRQ_CHANGE] <= (irq_stat[`BGL_IRQ_CHANGE] & ~irq_clr[`BGL_IRQ_CHANGE]) |
                                   (GEN_OUT != out_prev);
      IRQ <= |(irq_stat & irq_en[2:0] & ~irq_clr);
    end
  end

endmodule // bgl_top

`default_nettype wire

// File: sim/bgl_partner.sv
`timescale 1ns/1ps
`default_nettype none
module bgl_partner (
  input wire logic mclk,
  input wire logic [7:0] pin_set,
  input wire logic [199:0] rail_set,
  output logic [7:0] pin = 8'h00,
  output logic [199:0] rail = '0
);
  // Switches and monitors settle a clock after the request, never mid-cycle
  always @(posedge mclk) begin
    pin <= pin_set;
    rail <= rail_set;
  end
endmodule // bgl_partner
`default_nettype wire

// File: sim/bgl_top_assertions.sv
`timescale 1ns/1ps
`include "bgl_consts.svh"
`default_nettype none
module bgl_top_assertions (
  input wire logic MCLK,
  input wire logic RST_B,
  input wire logic CE,
  input wire logic [`BGL_NUM_IN-1:0] GEN_IN_PIN,
  input wire logic [9:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  input wire logic AVS_WAITREQUEST,
  input wire logic [`BGL_NUM_OUT-1:0] GEN_OUT,
  input wire logic [`BGL_NUM_OUT-1:0] GEN_OUT_OE,
  input wire logic [`BGL_NUM_RAIL-1:0] MARGIN_EN,
  input wire logic MARGIN_LOW,
  input wire logic IN_FAULT,
  input wire logic [`BGL_PSEL_NUM-1:0] PIN_SEL,
  input wire logic IRQ
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_B);
  logic [`BGL_NUM_IN-1:0] pin_q;
  logic [3:0] quiet;
  wire logic req = AVS_READ | AVS_WRITE;
  wire logic took_wr = AVS_WRITE & ~AVS_WAITREQUEST;
  // Cycles since pin or register activity; pin effects need three edges
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      pin_q <= '0;
      quiet <= '0;
    end else begin
      pin_q <= GEN_IN_PIN;
      if (GEN_IN_PIN != pin_q || took_wr) begin
        quiet <= '0;
      end else if (quiet != 4'hF) begin
        quiet <= quiet + 4'h1;
      end
    end
  end
  property p_wait_first;
    $rose(req) |-> AVS_WAITREQUEST;
  endproperty
  a_wait_first: assert property (p_wait_first) else $error("request answered with no wait cycle");
  property p_one_wait;
    (req && AVS_WAITREQUEST && CE) ##1 CE |-> !AVS_WAITREQUEST;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("wait lasted more than one cycle");
  property p_idle_ready;
    !req |-> !AVS_WAITREQUEST;
  endproperty
  a_idle_ready: assert property (p_idle_ready) else $error("wait raised with no request");
  property p_ce_hold;
    req && !CE |-> AVS_WAITREQUEST;
  endproperty
  a_ce_hold: assert property (p_ce_hold) else $error("bus answered while frozen");
  property p_oe_write;
    $changed(GEN_OUT_OE) |-> $past(took_wr) || $past(took_wr, 2);
  endproperty
  a_oe_write: assert property (p_oe_write) else $error("output enable moved without a write");
  for (genvar o = 0; o < `BGL_NUM_OUT; o++) begin : g_host
    property p_host_level;
      took_wr && AVS_ADDRESS == 10'(o * 16) && AVS_BYTEENABLE[0] && AVS_WRITEDATA[`BGL_CFG_HOST]
        |-> ##3 GEN_OUT[o] == $past(AVS_WRITEDATA[`BGL_CFG_LEVEL], 3);
    endproperty
    a_host_level: assert property (p_host_level) else $error("host level not on output");
  end
  property p_psel_cause;
    $changed(PIN_SEL) |-> quiet < 4'h6;
  endproperty
  a_psel_cause: assert property (p_psel_cause) else $error("selector bits moved unprompted");
  property p_fault_cause;
    $changed(IN_FAULT) |-> quiet < 4'h6;
  endproperty
  a_fault_cause: assert property (p_fault_cause) else $error("fault moved unprompted");
  property p_margin_cause;
    $changed({MARGIN_EN, MARGIN_LOW}) |-> quiet < 4'h6;
  endproperty
  a_margin_cause: assert property (p_margin_cause) else $error("margin moved unprompted");
  c_host: cover property (took_wr && AVS_WRITEDATA[`BGL_CFG_HOST]);
  c_fault: cover property ($rose(IN_FAULT));
  c_irq: cover property ($rose(IRQ));
endmodule // bgl_top_assertions
bind bgl_top bgl_top_assertions u_bgl_top_assertions (
  .MCLK(MCLK), .RST_B(RST_B), .CE(CE), .GEN_IN_PIN(GEN_IN_PIN), .AVS_ADDRESS(AVS_ADDRESS),
  .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
  .AVS_WAITREQUEST(AVS_WAITREQUEST), .GEN_OUT(GEN_OUT), .GEN_OUT_OE(GEN_OUT_OE), .MARGIN_EN(MARGIN_EN),
  .MARGIN_LOW(MARGIN_LOW), .IN_FAULT(IN_FAULT), .PIN_SEL(PIN_SEL), .IRQ(IRQ)
);
`default_nettype wire

// File: sim/bgl_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
module bgl_top_bench;
  import bgl_pkg::*;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic ce = 1'b1;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [9:0] addr = '0;
  bgl_word_t wdata = '0;
  bgl_word_t rdata;
  bgl_word_t rv;
  logic [7:0] pin_set = '0;
  logic [199:0] rail_set = '0;
  logic [7:0] pins;
  logic [199:0] rails;
  logic waitreq, mlow, fault, irq;
  logic [9:0] gout, goe, men;
  logic [2:0] psel;
  int bad_count = 0;
  int n_compared = 0;
  always #5 mclk = ~mclk;
  bgl_partner u_bgl_partner (.mclk(mclk), .pin_set(pin_set), .rail_set(rail_set), .pin(pins), .rail(rails));
  bgl_top u_bgl_top (.MCLK(mclk), .RST_B(rst_b), .CE(ce), .GEN_IN_PIN(pins), .RAIL_STATUS(rails),
    .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(4'hF),
    .AVS_READDATA(rdata), .AVS_WAITREQUEST(waitreq), .GEN_OUT(gout), .GEN_OUT_OE(goe), .MARGIN_EN(men),
    .MARGIN_LOW(mlow), .IN_FAULT(fault), .PIN_SEL(psel), .IRQ(irq));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic setp(input int i, input logic v, input int n);
    pin_set[i] <= v;
    cyc(n);
  endtask
  // Request held until waitrequest is seen low at an edge; fz freezes the clock enable first
  task automatic bus(input logic w, input logic [9:0] a, input bgl_word_t d, input logic fz);
    int n;
    n = 0;
    addr <= a;
    wdata <= d;
    rd <= ~w;
    wr <= w;
    if (fz) begin
      ce <= 1'b0;
      cyc(4);
      check("wait_frozen", waitreq, 1);
      ce <= 1'b1;
    end
    do begin
      @(posedge mclk);
      n++;
    end while (waitreq !== 1'b0 && n < 50);
    check("bus_answer", n < 50, 1);
    rv = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic w32(input logic [9:0] a, input bgl_word_t d);
    bus(1'b1, a, d, 1'b0);
  endtask
  task automatic t_reset;
    check("gen_out_rst", gout, '0);
    bus(1'b0, 10'h100, '0, 1'b1);
    check("in_cfg_rst", rv, 32'h0000_00FF);
    bus(1'b0, 10'h120, '0, 1'b0);
    check("unmapped", rv, '0);
    bus(1'b0, 10'h10C, '0, 1'b0);
    check("clear_reads_zero", rv, '0);
  endtask
  task automatic t_logic;
    w32(10'h014, 32'h0000_0100);
    w32(10'h018, 32'h0820_0000);
    w32(10'h064, 32'h0000_0002);
    setp(0, 1'b1, 10);
    check("and_input", gout[1], 1);
    check("out_as_input", gout[6], 1);
    setp(0, 1'b0, 10);
    check("and_low", gout[1], 0);
    rail_set[25] <= 1'b1;
    cyc(10);
    check("rail_term", gout[1], 1);
    rail_set[25] <= 1'b0;
    w32(10'h100, 32'h0000_00FE);
    cyc(10);
    check("active_low", gout[1], 1);
    w32(10'h100, 32'h0000_00FF);
  endtask
  task automatic t_latch;
    w32(10'h024, 32'h8C02_0000);
    rail_set[31] <= 1'b1;
    cyc(4);
    rail_set[31] <= 1'b0;
    cyc(10);
    check("latched_hold", gout[2], 1);
    w32(10'h10C, 32'h0000_0001);
    cyc(6);
    check("latch_cmd_clr", gout[2], 0);
    w32(10'h104, 32'h0000_00B0);
    rail_set[31] <= 1'b1;
    cyc(4);
    rail_set[31] <= 1'b0;
    setp(3, 1'b1, 10);
    check("latch_pin_clr", gout[2], 0);
    setp(3, 1'b0, 4);
  endtask
  task automatic t_host_irq;
    w32(10'h114, 32'h0000_0007);
    w32(10'h118, 32'h0000_0004);
    w32(10'h030, 32'h0000_0043);
    cyc(6);
    check("host_high", gout[3], 1);
    check("oe", goe[3], 1);
    check("irq_set", irq, 1);
    bus(1'b0, 10'h110, '0, 1'b0);
    check("irq_stat", rv[2], 1);
    w32(10'h114, 32'h0000_0004);
    w32(10'h118, 32'h0000_0000);
    w32(10'h030, 32'h0000_0041);
    cyc(6);
    check("host_low", gout[3], 0);
    check("irq_masked", irq, 0);
  endtask
  task automatic t_delay;
    int n;
    w32(10'h044, 32'h0000_0200);
    w32(10'h04C, 32'h0000_0002);
    w32(10'h040, 32'h0000_0004);
    setp(1, 1'b1, 180);
    setp(1, 1'b0, 20);
    setp(1, 1'b1, 100);
    check("glitch", gout[4], 0);
    cyc(250);
    check("assert_delay", gout[4], 1);
    setp(1, 1'b0, 8);
    check("deassert_now", gout[4], 0);
    w32(10'h040, 32'h0000_0014);
    setp(1, 1'b1, 30);
    pin_set[1] <= 1'b0;
    n = 0;
    while (gout[4] !== 1'b1 && n < 400) begin
      cyc(1);
      n++;
    end
    check("ignore_pass", gout[4], 1);
    n = 0;
    while (gout[4] === 1'b1 && n < 600) begin
      cyc(1);
      n++;
    end
    check("min_width", n >= 200, 1);
  endtask
  task automatic t_sm;
    w32(10'h054, 32'h0000_0400);
    w32(10'h058, 32'h0000_0800);
    w32(10'h050, 32'h0000_0020);
    setp(2, 1'b1, 1);
    setp(3, 1'b1, 10);
    check("sm_set", gout[5], 1);
    setp(3, 1'b0, 1);
    setp(2, 1'b0, 10);
    check("sm_drop", gout[5], 0);
    setp(2, 1'b1, 10);
    check("sm_term1", gout[5], 0);
  endtask
  task automatic t_funcs;
    w32(10'h100, 32'h0000_52FF);
    w32(10'h104, 32'h0000_EDBC);
    w32(10'h108, 32'h0000_00A5);
    pin_set[6:4] <= 3'h7;
    cyc(10);
    check("no_fault", fault, 0);
    check("margin_en", men, 10'h0A5);
    check("margin_low", mlow, 1);
    check("pin_sel", psel, 3'h6);
    setp(6, 1'b0, 10);
    check("margin_high", mlow, 0);
    setp(4, 1'b0, 10);
    check("fault", fault, 1);
    check("pin_sel2", psel, 3'h0);
    setp(5, 1'b0, 10);
    check("margin_off", men, 0);
    w32(10'h104, 32'h0000_EDBF);
    setp(7, 1'b1, 10);
    check("fault_moved", fault, 0);
  endtask
  task automatic final_report;
    $display("Compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    cyc(10);
    rst_b <= 1'b1;
    cyc(2);
    t_reset;
    t_logic;
    t_latch;
    t_host_irq;
    t_delay;
    t_sm;
    t_funcs;
    final_report;
  end
  // Whole sequence needs about 1400 cycles
  initial begin
    cyc(20000);
    bad_count++;
    final_report;
  end
endmodule // bgl_top_bench
`default_nettype wire
